/* File: t1aci_pkg.sv */
`default_nettype none
package t1aci_pkg;

  // clock and persistence times
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned CYCLES_PER_MS    = CLK_MHZ * 1000;
  localparam int unsigned ONES_PERSIST_MS  = 42;
  localparam int unsigned YEL_PERSIST_MS   = 900;
  localparam int unsigned ONES_CYCLES      = ONES_PERSIST_MS * CYCLES_PER_MS;
  localparam int unsigned YEL_CYCLES       = YEL_PERSIST_MS * CYCLES_PER_MS;
  localparam int unsigned YEL_CLEAR_CYCLES = 0;  // remote alarm clears at once

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_FRAMING_CFG = 14'h010b;
  localparam logic [13:0] IDX_IRQ_STATUS  = 14'h0b02;
  localparam logic [13:0] IDX_IRQ_ENABLE  = 14'h0b03;
  localparam logic [15:0] ADDR_FRAMING_CFG = {IDX_FRAMING_CFG, 2'b00};
  localparam logic [15:0] ADDR_IRQ_STATUS  = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [15:0] ADDR_IRQ_ENABLE  = {IDX_IRQ_ENABLE, 2'b00};

  // bit positions shared by status and enable
  localparam int unsigned BIT_REMOTE    = 0;
  localparam int unsigned BIT_ALL_ONES  = 1;
  localparam int unsigned BIT_FRAMELOSS = 2;
  localparam int unsigned SRC_W         = 3;
  localparam int unsigned STATE_LSB     = 5;  // live defect states in status 7..5

  // framing config fields
  localparam int unsigned CFG_FIELD_W   = 4;
  localparam int unsigned CFG_WIN_LSB   = 0;
  localparam int unsigned CFG_TOL_LSB   = 4;
  localparam logic [3:0]  RST_WINDOW    = 4'h4;
  localparam logic [3:0]  RST_TOLERANCE = 4'h2;
  localparam logic [2:0]  RST_ENABLE    = 3'h0;
  localparam logic [2:0]  RST_STATUS    = 3'h0;

endpackage
`default_nettype wire

/* File: t1aci_qual_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface t1aci_qual_if;
  logic condition;  // raw alarm condition from the framer
  logic defect;     // qualified defect state
  modport owner  (output condition, input defect);
  modport filter (input condition, output defect);
endinterface
`default_nettype wire

/* File: t1aci_persist_filter.sv */
`timescale 1ns/10ps
`default_nettype none
module t1aci_persist_filter #(
  parameter int DECLARE_CYCLES = 1,
  parameter int CLEAR_CYCLES   = 0,
  parameter int CNT_W          = 32
) (
  input  wire logic            mclk,
  input  wire logic            arst_n,
  t1aci_qual_if.filter         q
);
  import t1aci_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             defect;
  } t1aci_flt_state_t;

  t1aci_flt_state_t st;
  t1aci_flt_state_t next_st;

  // count consecutive cycles of the condition (or its absence) before toggling
  always_comb begin
    next_st = st;
    if (!st.defect) begin
      if (q.condition) begin
        if (st.count >= CNT_W'(DECLARE_CYCLES - 1)) begin
          next_st.defect = 1'b1;
          next_st.count  = '0;
        end else begin
          next_st.count = st.count + 1'b1;
        end
      end else begin
        next_st.count = '0;  // persistence must be unbroken
      end
    end else begin
      if (!q.condition) begin
        // zero clear time means the defect drops on the first absent cycle
        if ((CLEAR_CYCLES == 0) || (st.count >= CNT_W'(CLEAR_CYCLES - 1))) begin
          next_st.defect = 1'b0;
          next_st.count  = '0;
        end else begin
          next_st.count = st.count + 1'b1;
        end
      end else begin
        next_st.count = '0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q.defect = st.defect;

endmodule // t1aci_persist_filter
`default_nettype wire

/* File: t1aci_alarm_change_irq.sv */
// Functional notes
// RL1: status bit 2 records any change of the frame-loss defect since the last status read.
// RL2: frame loss is declared when the tolerance count of framing-bit errors falls in the window.
// RL3: an enabled frame-loss change interrupt fires both on declare and on clear.
// RL4: status bit 1 records any change of the all-ones alarm since the last status read.
// RL5: an enabled all-ones change interrupt fires both on declare and on clear.
// RL6: status bit 0 records any change of the remote alarm since the last status read.
// RL7: an enabled remote alarm change interrupt fires both on declare and on clear.
// RL8: each change bit clears when software reads the status register.
// RL9: a change reaches the interrupt output only while its enable bit is set.
// RL10: enable bits 7..5 are reserved and read as zero.
// RL11: software writes zero to enable bit 4; the block ignores it and reads it as zero.
// RL12: enable bit 1 gates the all-ones change interrupt.
// RL13: enable bit 0 gates the remote alarm change interrupt.
// RL14: the all-ones defect is declared and cleared after 42 ms of steady condition.
// RL15: the remote alarm is declared after 900 ms and cleared at once when absent.
// RL16: a change is seen by comparing each defect with its value one cycle earlier.
// RL17: a change that coincides with a status read keeps its bit set.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module t1aci_alarm_change_irq #(
  parameter int ONES_DECLARE = t1aci_pkg::ONES_CYCLES,
  parameter int YEL_DECLARE  = t1aci_pkg::YEL_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        framingBitTick,
  input  wire logic        framingBitError,
  input  wire logic        allOnesCondition,
  input  wire logic        remoteAlarmCondition,
  output logic             irq
);
  import t1aci_pkg::*;

  typedef struct packed {
    logic [7:0]             rdData;
    logic                   slvErr;
    logic [SRC_W-1:0]       readMask;
    logic [CFG_FIELD_W-1:0] tolerance;
    logic [CFG_FIELD_W-1:0] window;
    logic [CFG_FIELD_W-1:0] fbCount;
    logic [CFG_FIELD_W-1:0] errCount;
    logic                   frameLoss;
    logic [SRC_W-1:0]       prevDefect;
    logic [SRC_W-1:0]       status;
    logic [SRC_W-1:0]       enable;
  } t1aci_state_t;

  t1aci_state_t           st;
  t1aci_state_t           next_st;
  logic                   setupPh;
  logic                   accessPh;
  logic [SRC_W-1:0]       defects;
  logic [SRC_W-1:0]       changeEv;
  logic [SRC_W-1:0]       clearMask;
  logic                   addrHit;
  logic [CFG_FIELD_W-1:0] fbNext;
  logic [CFG_FIELD_W-1:0] errNext;

  t1aci_qual_if onesQ ();
  t1aci_qual_if yelQ ();

  // persistence filters for the all-ones and remote alarm conditions
  assign onesQ.condition = allOnesCondition;
  assign yelQ.condition  = remoteAlarmCondition;

  t1aci_persist_filter #(
    .DECLARE_CYCLES (ONES_DECLARE),
    .CLEAR_CYCLES   (ONES_DECLARE),
    .CNT_W          (32)
  ) u_ones_filter (
    .mclk   (mclk),
    .arst_n (arst_n),
    .q      (onesQ.filter)
  ); // [RL14]

  t1aci_persist_filter #(
    .DECLARE_CYCLES (YEL_DECLARE),
    .CLEAR_CYCLES   (YEL_CLEAR_CYCLES),
    .CNT_W          (32)
  ) u_yel_filter (
    .mclk   (mclk),
    .arst_n (arst_n),
    .q      (yelQ.filter)
  ); // [RL15]

  // apb phases; access always completes in one cycle
  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign addrHit  = (paddr == ADDR_FRAMING_CFG) | (paddr == ADDR_IRQ_STATUS) |
                    (paddr == ADDR_IRQ_ENABLE);

  // live defect vector and its edges against last cycle
  assign defects = {st.frameLoss, onesQ.defect, yelQ.defect};
  assign changeEv = defects ^ st.prevDefect; // [RL16]

  assign fbNext  = st.fbCount + 1'b1;
  assign errNext = st.errCount + {{(CFG_FIELD_W-1){1'b0}}, framingBitError};

  always_comb begin
    next_st            = st;
    clearMask          = '0;
    next_st.prevDefect = defects; // [RL16]

    // framing-bit error counting over a block window
    if (framingBitTick) begin
      next_st.fbCount  = fbNext;
      next_st.errCount = errNext;
      if (!st.frameLoss && (st.tolerance != '0) && (errNext >= st.tolerance)) begin
        next_st.frameLoss = 1'b1; // [RL2]
        next_st.fbCount   = '0;
        next_st.errCount  = '0;
      end else if (fbNext >= st.window) begin
        // recovery needs one clean window; keeps frame loss from chattering
        if (st.frameLoss && (errNext == '0)) begin
          next_st.frameLoss = 1'b0;
        end
        next_st.fbCount  = '0;
        next_st.errCount = '0;
      end
    end

    // setup phase: capture read data so prdata comes from a flop
    if (setupPh) begin
      next_st.slvErr   = ~addrHit;
      next_st.readMask = '0;
      next_st.rdData   = 8'h00;
      if (!pwrite) begin
        unique case (paddr)
          ADDR_FRAMING_CFG: begin
            next_st.rdData = {st.tolerance, st.window};
          end
          ADDR_IRQ_STATUS: begin
            next_st.rdData   = {defects, 2'b00, st.status};
            next_st.readMask = st.status; // only bits shown are cleared
          end
          ADDR_IRQ_ENABLE: begin
            next_st.rdData = {5'b00000, st.enable}; // [RL10] [RL11]
          end
          default: begin
            next_st.rdData = 8'h00;
          end
        endcase
      end
    end

    // access phase: writes take effect, reads clear the reported bits
    if (accessPh) begin
      if (pwrite) begin
        unique case (paddr)
          ADDR_FRAMING_CFG: begin
            next_st.window    = pwdata[CFG_WIN_LSB +: CFG_FIELD_W];
            next_st.tolerance = pwdata[CFG_TOL_LSB +: CFG_FIELD_W];
          end
          ADDR_IRQ_STATUS: begin
            clearMask = pwdata[SRC_W-1:0];  // write one to clear
          end
          ADDR_IRQ_ENABLE: begin
            next_st.enable = pwdata[SRC_W-1:0]; // bit 3 and up dropped [RL11]
          end
          default: begin
            clearMask = '0;
          end
        endcase
      end else if (paddr == ADDR_IRQ_STATUS) begin
        clearMask = st.readMask; // [RL8]
      end
      next_st.readMask = '0;
    end

    // set wins over clear so a coincident event survives
    next_st.status = (st.status & ~clearMask) | changeEv; // [RL1] [RL4] [RL6] [RL17]
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st            <= '0;
      st.tolerance  <= RST_TOLERANCE;
      st.window     <= RST_WINDOW;
      st.enable     <= RST_ENABLE;
      st.status     <= RST_STATUS;
    end else begin
      st <= next_st;
    end
  end

  // bus outputs; slave error only for unmapped addresses
  assign prdata  = {24'h00_0000, st.rdData};
  assign pready  = accessPh;
  assign pslverr = accessPh & st.slvErr;

  // one level interrupt from enabled sticky bits
  assign irq = |(st.status & st.enable); // [RL3] [RL5] [RL7] [RL9] [RL12] [RL13]

  // checks on the change logic and register map
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence s_status_read;
    psel && penable && !pwrite && (paddr == ADDR_IRQ_STATUS);
  endsequence

  sequence s_enable_setup;
    psel && !penable && !pwrite && (paddr == ADDR_IRQ_ENABLE);
  endsequence

  sequence s_enable_write;
    psel && penable && pwrite && (paddr == ADDR_IRQ_ENABLE);
  endsequence

  sequence s_status_write;
    psel && penable && pwrite && (paddr == ADDR_IRQ_STATUS);
  endsequence

  a_frameloss_change_sets: assert property ( // [RL1] [RL3]
    changeEv[BIT_FRAMELOSS] |=> st.status[BIT_FRAMELOSS])
    else $error("frame-loss change did not set its status bit");

  a_all_ones_change_sets: assert property ( // [RL4] [RL5]
    $changed(onesQ.defect) |=> st.status[BIT_ALL_ONES])
    else $error("all-ones change did not set its status bit");

  a_remote_change_sets: assert property ( // [RL6] [RL7] [RL16]
    $changed(yelQ.defect) |=> st.status[BIT_REMOTE])
    else $error("remote alarm change did not set its status bit");

  a_read_clears_bits: assert property ( // [RL8]
    s_status_read ##0 (changeEv == 3'b000) |=> ((st.status & $past(st.readMask)) == 3'b000))
    else $error("status read left a reported bit set");

  a_read_keeps_event: assert property ( // [RL17]
    s_status_read ##0 (changeEv != 3'b000) |=>
      ((st.status & $past(changeEv)) == $past(changeEv)))
    else $error("change during status read was lost");

  a_irq_all_masked: assert property ( // [RL9]
    (st.enable == 3'b000) |-> !irq)
    else $error("interrupt raised with all enables clear");

  a_irq_all_ones_gate: assert property ( // [RL12]
    (st.status == 3'b010) && st.enable[BIT_ALL_ONES] |-> irq)
    else $error("enabled all-ones change did not raise interrupt");

  a_irq_remote_gate: assert property ( // [RL13]
    (st.status == 3'b001) && !st.enable[BIT_REMOTE] |-> !irq)
    else $error("disabled remote change raised interrupt");

  a_enable_reserved: assert property ( // [RL10]
    s_enable_setup |=> (prdata[31:3] == 29'h0000_0000))
    else $error("reserved enable bits did not read zero");

  a_all_ones_persist: assert property ( // [RL14]
    $rose(onesQ.defect) |-> $past(allOnesCondition, 1))
    else $error("all-ones declared without the condition present");

  a_remote_fast_clear: assert property ( // [RL15]
    yelQ.defect && !remoteAlarmCondition |=> !yelQ.defect)
    else $error("remote alarm not cleared at once");

  a_frameloss_declare: assert property ( // [RL2]
    $rose(st.frameLoss) |-> $past(framingBitTick && framingBitError, 1))
    else $error("frame loss declared without a framing error");

  // recovery only on a tick that closes a clean window
  a_frameloss_clean_clear: assert property ( // [RL2]
    $fell(st.frameLoss) |-> $past(framingBitTick && !framingBitError, 1))
    else $error("frame loss cleared on a bad framing bit");

  a_ones_clear_cond: assert property ( // [RL14]
    $fell(onesQ.defect) |-> $past(!allOnesCondition, 1))
    else $error("all-ones cleared while the condition stood");

  a_remote_declare_cond: assert property ( // [RL15]
    $rose(yelQ.defect) |-> $past(remoteAlarmCondition, 1))
    else $error("remote alarm declared without the condition");

  // sticky bits move only on an event or a bus access
  a_status_sticky: assert property ( // [RL1] [RL4] [RL6]
    (changeEv == 3'b000) && !accessPh |=> (st.status == $past(st.status)))
    else $error("status changed with no event and no access");

  a_w1c_clears: assert property ( // [RL8]
    s_status_write ##0 (changeEv == 3'b000) |=>
      ((st.status & $past(pwdata[SRC_W-1:0])) == 3'b000))
    else $error("write one to status left a bit set");

  a_enable_write_lands: assert property ( // [RL12] [RL13]
    s_enable_write |=> (st.enable == $past(pwdata[SRC_W-1:0])))
    else $error("enable write did not land");

  a_irq_remote_on: assert property ( // [RL7] [RL13]
    st.status[BIT_REMOTE] && st.enable[BIT_REMOTE] |-> irq)
    else $error("enabled remote change did not raise interrupt");

  a_irq_frameloss_on: assert property ( // [RL3] [RL9]
    st.status[BIT_FRAMELOSS] && st.enable[BIT_FRAMELOSS] |-> irq)
    else $error("enabled frame-loss change did not raise interrupt");

  a_irq_ones_masked: assert property ( // [RL12]
    (st.status == 3'b010) && !st.enable[BIT_ALL_ONES] |-> !irq)
    else $error("disabled all-ones change raised interrupt");

endmodule // t1aci_alarm_change_irq
`default_nettype wire

/* File: t1aci_framer_model.sv */
`timescale 1ns/10ps
`default_nettype none
module t1aci_framer_model (
  input  wire logic mclk,
  output logic      framingBitTick,
  output logic      framingBitError,
  output logic      allOnesCondition,
  output logic      remoteAlarmCondition
);
  // line is quiet until the bench asks for alarms
  initial begin
    framingBitTick = 1'b0;
    framingBitError = 1'b0;
    allOnesCondition = 1'b0;
    remoteAlarmCondition = 1'b0;
  end
  // framing bits four cycles apart; the error flag flips off-tick,
  // so the block must not lean on it between ticks
  task automatic bits(input int n, input logic err);
    repeat (n) begin
      @(posedge mclk);
      framingBitTick <= 1'b1;
      framingBitError <= err;
      @(posedge mclk);
      framingBitTick <= 1'b0;
      framingBitError <= ~err;
      repeat (2) @(posedge mclk);
    end
  endtask
  // hold one raw alarm (ones=1 all-ones, else remote) at v for n cycles
  task automatic hold(input logic ones, input logic v, input int n);
    @(posedge mclk);
    if (ones) allOnesCondition <= v;
    else remoteAlarmCondition <= v;
    // the next call moves the pin on the n-th edge, so v is sampled n times
    repeat (n - 1) @(posedge mclk);
  endtask
endmodule  // t1aci_framer_model
`default_nettype wire

/* File: test_t1_alarm_change_interrupt.sv */
`timescale 1ns/10ps
`default_nettype none
module test_t1_alarm_change_interrupt;
  import t1aci_pkg::*;
  logic        mclk, arst_n, psel, penable, pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        pready, pslverr, tick, tickErr, allOnes, remote, irq, rerr;
  logic [7:0]  en;
  int          nMismatch, checks, cycles;

  t1aci_alarm_change_irq #(.ONES_DECLARE(8), .YEL_DECLARE(20)) dut (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .framingBitTick(tick),
    .framingBitError(tickErr), .allOnesCondition(allOnes),
    .remoteAlarmCondition(remote), .irq(irq));
  t1aci_framer_model model (.mclk(mclk), .framingBitTick(tick),
    .framingBitError(tickErr), .allOnesCondition(allOnes),
    .remoteAlarmCondition(remote));

  // 100 MHz bus clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // watchdog; the sequence needs under two thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      nMismatch = nMismatch + 1;
      report_and_stop();
    end
  end

  function automatic logic [31:0] stat(input logic [2:0] st, input logic [2:0] chg);
    return {24'h0000_00, st, 2'b00, chg};
  endfunction
  function automatic logic [31:0] expIrq(input logic [2:0] chg, input logic [2:0] e);
    return 32'(|(chg & e));
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      nMismatch = nMismatch + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one transfer; the request stays put until pready is sampled high
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rdata, exp);
  endtask
  // irq is looked at mid-cycle, once flop updates have landed
  task automatic chkIrq(input string what, input logic [31:0] exp);
    @(negedge mclk);
    chk(what, 32'(irq), exp);
  endtask
  task automatic done(input string t);
    $display("test %s finished", t);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    {psel, penable, pwrite} = 3'b000;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    arst_n = 1'b0;
    void'($urandom(32'hde6c_f9dc));
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    rd(ADDR_FRAMING_CFG, 32'h0000_0024, "cfg");
    rd(ADDR_IRQ_ENABLE, 32'h0000_0000, "enable");
    rd(ADDR_IRQ_STATUS, stat(3'b000, 3'b000), "status");
    rd(16'h0000, 32'h0000_0000, "hole");
    chk("hole err", 32'(rerr), 32'h0000_0001);
    done("reset");
    // random enables, bit 4 always written as zero
    repeat (6) begin
      en = 8'($urandom) & 8'hef;
      apb(1'b1, ADDR_IRQ_ENABLE, 32'(en));
      rd(ADDR_IRQ_ENABLE, 32'(en[2:0]), "enable rd");
      chkIrq("irq idle", 32'h0000_0000);
    end
    done("enable");
    // all-ones: too short, then masked declare, then enabled clear
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0000);
    model.hold(1'b1, 1'b1, 7);
    model.hold(1'b1, 1'b0, 3);
    rd(ADDR_IRQ_STATUS, stat(3'b000, 3'b000), "ones short");
    model.hold(1'b1, 1'b1, 10);
    chkIrq("irq masked", expIrq(3'b010, 3'b000));
    rd(ADDR_IRQ_STATUS, stat(3'b010, 3'b010), "ones up");
    rd(ADDR_IRQ_STATUS, stat(3'b010, 3'b000), "ones reread");
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0002);
    model.hold(1'b1, 1'b0, 10);
    chkIrq("irq ones", expIrq(3'b010, 3'b010));
    rd(ADDR_IRQ_STATUS, stat(3'b000, 3'b010), "ones down");
    chkIrq("irq read", 32'h0000_0000);
    done("all ones");
    // remote alarm: one cycle short, then declare, then immediate clear
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0001);
    model.hold(1'b0, 1'b1, 19);
    model.hold(1'b0, 1'b0, 3);
    rd(ADDR_IRQ_STATUS, stat(3'b000, 3'b000), "yel short");
    model.hold(1'b0, 1'b1, 22);
    chkIrq("irq yel", expIrq(3'b001, 3'b001));
    rd(ADDR_IRQ_STATUS, stat(3'b001, 3'b001), "yel up");
    model.hold(1'b0, 1'b0, 3);
    rd(ADDR_IRQ_STATUS, stat(3'b000, 3'b001), "yel down");
    done("remote");
    // frame loss: one error in a window, then two, then a clean window
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0004);
    model.bits(1, 1'b1);
    model.bits(3, 1'b0);
    rd(ADDR_IRQ_STATUS, stat(3'b000, 3'b000), "one error");
    model.bits(2, 1'b1);
    chkIrq("irq frame loss", expIrq(3'b100, 3'b100));
    rd(ADDR_IRQ_STATUS, stat(3'b100, 3'b100), "loss up");
    model.bits(4, 1'b0);
    rd(ADDR_IRQ_STATUS, stat(3'b000, 3'b100), "loss down");
    done("frame loss");
    // corners: a remote clear lands on the access edge of a status read
    model.hold(1'b0, 1'b1, 22);
    fork
      model.hold(1'b0, 1'b0, 3);
      rd(ADDR_IRQ_STATUS, stat(3'b001, 3'b001), "yel at read");
    join
    rd(ADDR_IRQ_STATUS, stat(3'b000, 3'b001), "yel kept");
    // write one to clear, with the defect still standing
    model.hold(1'b0, 1'b1, 22);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0001);
    rd(ADDR_IRQ_STATUS, stat(3'b001, 3'b000), "w1c");
    // random framing settings read back; no ticks follow, so loss stays put
    en = 8'($urandom);
    apb(1'b1, ADDR_FRAMING_CFG, 32'(en));
    rd(ADDR_FRAMING_CFG, 32'(en), "cfg rd");
    done("corners");
    report_and_stop();
  end
endmodule  // test_t1_alarm_change_interrupt
`default_nettype wire
